// ---- fcsl_pkg.sv ----
// shared constants and types for the flash command status logic
`default_nettype none
package fcsl_pkg;
    // register word indices, byte address is four times the index
    localparam logic [5:0] IDX_STATUS  = 6'h05;
    localparam logic [5:0] IDX_COMMAND = 6'h06;
    localparam logic [5:0] IDX_IRQ_ST  = 6'h08;
    localparam logic [5:0] IDX_IRQ_MSK = 6'h09;
    localparam logic [5:0] IDX_CTRL    = 6'h0a;

    // flash_status bit positions
    localparam int STAT_CMD_BUFFER_EMPTY_FLAG = 7;
    localparam int STAT_CMD_COMPLETE_FLAG  = 6;
    localparam int STAT_PROTECT_VIOLATION_FLAG = 5;
    localparam int STAT_ACCER = 4;
    localparam int STAT_BLANK = 2;
    localparam int STAT_FAIL  = 1;
    localparam int STAT_DONE  = 0;

    // interrupt status and mask bit positions
    localparam int IRQ_CMD_COMPLETE_FLAG  = 0;
    localparam int IRQ_PROTECT_VIOLATION_FLAG = 1;
    localparam int IRQ_ACCER = 2;
    localparam int IRQ_FAIL  = 3;
    localparam int IRQ_W     = 4;

    // control register bit positions
    localparam int CTRL_SPECIAL = 0;

    // writable command code bits six, five, two and zero
    localparam logic [7:0] CMD_MASK       = 8'h65;
    localparam logic [7:0] CMD_ERASE_VER  = 8'h05;
    localparam logic [7:0] CMD_PROGRAM    = 8'h20;
    localparam logic [7:0] CMD_SECT_ERASE = 8'h40;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h41;

    localparam logic [7:0] RST_COMMAND = 8'h00;
    localparam logic [3:0] RST_IRQ     = 4'h0;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ADDR = 2'b01,
        SEQ_CMD  = 2'b11
    } fcsl_seq_t;

    // request to the program/erase engine
    typedef struct packed {
        logic       start;
        logic       abort;
        logic [7:0] code;
    } fcsl_eng_req_t;

    // answer from the program/erase engine
    typedef struct packed {
        logic done;
        logic blank;
    } fcsl_eng_rsp_t;
endpackage : fcsl_pkg
`default_nettype wire

// ---- fcsl_top.sv ----
// flash command status logic with classic wishbone register slave
//
// Register access over Wishbone was left to the implementer.
`default_nettype none
module fcsl_top #(
    parameter int ADR_W = 8
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    input  wire logic                   cyc_i,
    input  wire logic                   stb_i,
    input  wire logic                   we_i,
    input  wire logic [ADR_W-1:0]       adr_i,
    input  wire logic [3:0]             sel_i,
    input  wire logic [31:0]            dat_i,
    output logic      [31:0]            dat_o,
    output logic                        ack_o,
    input  wire logic                   stop_req_i,
    input  wire logic                   array_write_i,
    input  wire logic                   array_protected_i,
    input  wire logic                   any_protect_i,
    input  wire fcsl_pkg::fcsl_eng_rsp_t eng_rsp_i,
    output fcsl_pkg::fcsl_eng_req_t     eng_req_o,
    output logic                        irq_o
);
    import fcsl_pkg::*;

    if (ADR_W < 8) begin : g_chk
        $error("fcsl_top: ADR_W must be at least 8");
    end

    function automatic logic cmd_valid(input logic [7:0] code);
        cmd_valid = (code == CMD_ERASE_VER) || (code == CMD_PROGRAM) ||
                    (code == CMD_SECT_ERASE) || (code == CMD_MASS_ERASE);
    endfunction : cmd_valid

    fcsl_seq_t        seq;
    fcsl_seq_t        next_seq;
    logic [7:0]       cmd_reg;
    logic [7:0]       pend_code;
    logic [7:0]       cur_code;
    logic             busy;
    logic             pending;
    logic             protect_violation_flag;
    logic             access_error_flag;
    logic             blank;
    logic             fail;
    logic             special;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_msk;

    // bus decode
    logic       req;
    logic       acc;
    logic       wr;
    logic [5:0] idx;
    logic       wr_stat;
    logic       wr_cmd;
    logic       rd_irq;
    assign req     = cyc_i & stb_i;
    assign acc     = req & ack_o & ce_i;
    assign wr      = acc & we_i & sel_i[0];
    assign idx     = adr_i[7:2];
    assign wr_stat = wr & (idx == IDX_STATUS);
    assign wr_cmd  = wr & (idx == IDX_COMMAND);
    assign rd_irq  = acc & ~we_i & (idx == IDX_IRQ_ST);

    // derived status
    logic cmd_buffer_empty_flag;
    logic cmd_complete_flag;
    logic locked;
    logic done_flag;
    assign cmd_buffer_empty_flag     = ~pending;
    assign cmd_complete_flag      = ~busy & ~pending;
    assign locked    = protect_violation_flag | access_error_flag | fail;
    assign done_flag = special ? ~busy : 1'b1;

    // sequence events
    logic stop_abort;
    logic aw_ok;
    logic code_ok;
    logic launch_ok;
    logic pv_set;
    logic ae_set;
    assign stop_abort = stop_req_i & ~cmd_complete_flag;
    assign aw_ok      = array_write_i & (seq == SEQ_IDLE) & cmd_buffer_empty_flag & ~locked;
    assign code_ok    = cmd_valid(dat_i[7:0]);
    assign launch_ok  = wr_stat & dat_i[STAT_CMD_BUFFER_EMPTY_FLAG] & (seq == SEQ_CMD) & ~locked;
    assign pv_set     = (aw_ok & array_protected_i) |
                        (wr_cmd & (seq == SEQ_ADDR) & code_ok &
                         (dat_i[7:0] == CMD_MASS_ERASE) & any_protect_i);
    assign ae_set     = (array_write_i & ~((seq == SEQ_IDLE) & cmd_buffer_empty_flag)) |
                        (wr_cmd & ((seq != SEQ_ADDR) | ~code_ok)) |
                        (wr_stat & ~dat_i[STAT_CMD_BUFFER_EMPTY_FLAG] & (seq != SEQ_IDLE)) |
                        stop_abort;

    // engine issue
    logic done_now;
    logic free;
    logic issue_pend;
    logic issue_new;
    logic buffer_new;
    logic ev_done;
    logic ev_cmd_complete_flag;
    logic fail_set;
    assign done_now   = busy & eng_rsp_i.done;
    assign free       = ~busy | done_now;
    assign issue_pend = pending & free & ~stop_abort;
    assign issue_new  = launch_ok & free & ~pending & ~stop_abort;
    assign buffer_new = launch_ok & ~issue_new & ~stop_abort;
    assign ev_done    = done_now & (cur_code == CMD_ERASE_VER);
    assign ev_cmd_complete_flag    = done_now & ~pending & ~launch_ok & ~stop_abort;
    assign fail_set   = ev_done & ~eng_rsp_i.blank & special;

    always_comb begin
        next_seq = seq;
        case (seq)
            SEQ_IDLE: begin
                if (aw_ok && !array_protected_i) begin
                    next_seq = SEQ_ADDR;
                end
            end
            SEQ_ADDR: begin
                if (array_write_i || (wr_stat && !dat_i[STAT_CMD_BUFFER_EMPTY_FLAG])) begin
                    next_seq = SEQ_IDLE;
                end else if (wr_cmd) begin
                    next_seq = (code_ok && !pv_set) ? SEQ_CMD : SEQ_IDLE;
                end
            end
            SEQ_CMD: begin
                if (array_write_i || wr_cmd || (wr_stat && (!dat_i[STAT_CMD_BUFFER_EMPTY_FLAG] || launch_ok))) begin
                    next_seq = SEQ_IDLE;
                end
            end
            default: next_seq = SEQ_IDLE;
        endcase
        if (stop_abort) begin
            next_seq = SEQ_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq <= SEQ_IDLE;
        end else if (ce_i) begin
            seq <= next_seq;
        end
    end

    // command register keeps only the code bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_reg <= RST_COMMAND;
        end else if (ce_i && wr_cmd && seq == SEQ_ADDR && code_ok) begin
            cmd_reg <= dat_i[7:0] & CMD_MASK;
        end
    end

    // engine tracking
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy      <= 1'b0;
            pending   <= 1'b0;
            pend_code <= RST_COMMAND;
            cur_code  <= RST_COMMAND;
            eng_req_o <= '0;
        end else if (ce_i) begin
            eng_req_o.start <= issue_pend | issue_new;
            eng_req_o.abort <= stop_abort;
            if (stop_abort) begin
                busy    <= 1'b0;
                pending <= 1'b0;
            end else begin
                busy    <= issue_pend | issue_new | (busy & ~done_now);
                pending <= buffer_new | (pending & ~issue_pend);
            end
            if (buffer_new) begin
                pend_code <= cmd_reg;
            end
            if (issue_pend) begin
                cur_code       <= pend_code;
                eng_req_o.code <= pend_code;
            end else if (issue_new) begin
                cur_code       <= cmd_reg;
                eng_req_o.code <= cmd_reg;
            end
        end
    end

    // status flags, a set outranks a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            protect_violation_flag  <= 1'b0;
            access_error_flag <= 1'b0;
            blank  <= 1'b0;
            fail   <= 1'b0;
        end else if (ce_i) begin
            protect_violation_flag  <= pv_set | (protect_violation_flag & ~(wr_stat & dat_i[STAT_PROTECT_VIOLATION_FLAG]));
            access_error_flag <= ae_set | (access_error_flag & ~(wr_stat & dat_i[STAT_ACCER]));
            fail   <= fail_set | (fail & ~(wr_stat & dat_i[STAT_FAIL]));
            if (ev_done && eng_rsp_i.blank) begin
                blank <= 1'b1;
            end else if (launch_ok) begin
                blank <= 1'b0;
            end
        end
    end

    // control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            special <= 1'b0;
        end else if (ce_i && wr && idx == IDX_CTRL) begin
            special <= dat_i[CTRL_SPECIAL];
        end
    end

    // interrupt status, cleared by read of the reported bits
    logic [IRQ_W-1:0] irq_ev;
    assign irq_ev = {fail_set, ae_set, pv_set, ev_cmd_complete_flag};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st  <= RST_IRQ;
            irq_msk <= RST_IRQ;
        end else if (ce_i) begin
            irq_st <= irq_ev | (irq_st & ~(rd_irq ? dat_o[IRQ_W-1:0] : RST_IRQ));
            if (wr && idx == IDX_IRQ_MSK) begin
                irq_msk <= dat_i[IRQ_W-1:0];
            end
        end
    end

    assign irq_o = |(irq_st & irq_msk);

    // read mux, unmapped words read zero
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0000_0000;
        case (idx)
            IDX_STATUS: begin
                rd_val[STAT_CMD_BUFFER_EMPTY_FLAG] = cmd_buffer_empty_flag;
                rd_val[STAT_CMD_COMPLETE_FLAG]  = cmd_complete_flag;
                rd_val[STAT_PROTECT_VIOLATION_FLAG] = protect_violation_flag;
                rd_val[STAT_ACCER] = access_error_flag;
                rd_val[STAT_BLANK] = blank;
                rd_val[STAT_FAIL]  = fail;
                rd_val[STAT_DONE]  = done_flag;
            end
            IDX_COMMAND: rd_val[7:0]       = cmd_reg & CMD_MASK;
            IDX_IRQ_ST:  rd_val[IRQ_W-1:0] = irq_st;
            IDX_IRQ_MSK: rd_val[IRQ_W-1:0] = irq_msk;
            IDX_CTRL:    rd_val[CTRL_SPECIAL] = special;
            default:     rd_val = 32'h0000_0000;
        endcase
    end

    // one wait state, ack drops the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_o <= req & ~ack_o;
            if (req && !ack_o) begin
                dat_o <= rd_val;
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_launch;
        ce_i && launch_ok && !stop_abort;
    endsequence

    sequence s_locked_idle;
        ce_i && locked && !busy && !pending;
    endsequence

    property p_protect_violation_flag_set;
        ce_i && pv_set |=> protect_violation_flag;
    endproperty
    a_protect_violation_flag_set: assert property (p_protect_violation_flag_set) else $error("protect violation not set");
    property p_protect_violation_flag_hold;
        ce_i && protect_violation_flag && !(wr_stat && dat_i[STAT_PROTECT_VIOLATION_FLAG]) |=> protect_violation_flag;
    endproperty
    a_protect_violation_flag_hold: assert property (p_protect_violation_flag_hold) else $error("protect violation lost");
    property p_no_launch_locked;
        s_locked_idle |=> !eng_req_o.start;
    endproperty
    a_no_launch_locked: assert property (p_no_launch_locked) else $error("launch while locked");
    property p_stop_err;
        ce_i && stop_req_i && !cmd_complete_flag |=> access_error_flag && !busy && !pending;
    endproperty
    a_stop_err: assert property (p_stop_err) else $error("stop did not abort");

    property p_access_error_flag_hold;
        ce_i && access_error_flag && !(wr_stat && dat_i[STAT_ACCER]) |=> access_error_flag;
    endproperty
    a_access_error_flag_hold: assert property (p_access_error_flag_hold) else $error("access error lost");

    property p_launch;
        s_launch ##0 (!busy && !pending) |=> eng_req_o.start && !blank ##1 !eng_req_o.start;
    endproperty
    a_launch: assert property (p_launch) else $error("launch not issued once");

    property p_blank_set;
        ce_i && ev_done && eng_rsp_i.blank |=> blank;
    endproperty
    a_blank_set: assert property (p_blank_set) else $error("blank not set");

    property p_done_low;
        ce_i && special && eng_req_o.start && busy |-> !rd_val[STAT_DONE] || idx != IDX_STATUS;
    endproperty
    a_done_low: assert property (p_done_low) else $error("done high while busy");

    property p_cmd_bits;
        (cmd_reg & ~CMD_MASK) == 8'h00;
    endproperty
    a_cmd_bits: assert property (p_cmd_bits) else $error("reserved command bit set");

    property p_cmd_complete_flag;
        ce_i && ev_cmd_complete_flag |=> cmd_complete_flag;
    endproperty
    a_cmd_complete_flag: assert property (p_cmd_complete_flag) else $error("complete flag not set");

    property p_read_no_err;
        ce_i && acc && !we_i && !access_error_flag && !array_write_i && !stop_req_i |=> !access_error_flag;
    endproperty
    a_read_no_err: assert property (p_read_no_err) else $error("read raised access error");

    property p_reset;
        $past(rst_i) |-> !protect_violation_flag && !access_error_flag && !blank && !fail && cmd_reg == RST_COMMAND;
    endproperty
    a_reset: assert property (p_reset) else $error("flags not clear after reset");

    property p_set_wins;
        ce_i && ae_set && wr_stat && dat_i[STAT_ACCER] |=> access_error_flag;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat set");

    property p_ack;
        ce_i && ack_o |=> !ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack held two cycles");
endmodule : fcsl_top
`default_nettype wire

// ---- fcsl_eng_model.sv ----
// behavioural program/erase engine answering the start requests
`default_nettype none
module fcsl_eng_model (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire fcsl_pkg::fcsl_eng_req_t req_i,
    input  wire logic [7:0]              lat_i,
    input  wire logic                    blank_i,
    output var  fcsl_pkg::fcsl_eng_rsp_t rsp_o
);
    import fcsl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt;
    logic       run;
    // blank carries the inverse outside the done cycle
    always_ff @(posedge clk_i) begin
        rsp_o.done  <= 1'b0;
        rsp_o.blank <= ~blank_i;
        if (rst_i || req_i.abort) begin
            run <= 1'b0;
        end else if (req_i.start) begin
            run <= 1'b1;
            cnt <= lat_i;
        end else if (run) begin
            cnt <= cnt - 8'h01;
            if (cnt == 8'h00) begin
                run         <= 1'b0;
                rsp_o.done  <= 1'b1;
                rsp_o.blank <= blank_i;
            end
        end
    end
endmodule : fcsl_eng_model
`default_nettype wire

// ---- fcsl_top_tb.sv ----
// self-checking bench for the flash command status logic
`default_nettype none
module fcsl_top_tb;
    import fcsl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] A_ST  = 8'h14;
    localparam logic [7:0] A_CMD = 8'h18;
    localparam logic [7:0] A_IRQ = 8'h20;
    localparam logic [7:0] A_MSK = 8'h24;
    localparam logic [7:0] A_CTL = 8'h28;
    typedef struct packed {
        logic [7:0] code;
        logic       blank;
        logic [7:0] stat;
    } fcsl_row_t;
    localparam fcsl_row_t ROWS [5] = '{'{8'h05, 1'b1, 8'hc5}, '{8'h20, 1'b0, 8'hc1},
        '{8'h40, 1'b0, 8'hc1}, '{8'h41, 1'b0, 8'hc1}, '{8'h05, 1'b0, 8'hc1}};
    logic          clk_i = 1'b0;
    logic          rst_i = 1'b1;
    logic          ce    = 1'b1;
    logic          cyc   = 1'b0;
    logic          stb   = 1'b0;
    logic          we    = 1'b0;
    logic [7:0]    adr   = 8'h00;
    logic [3:0]    sel   = 4'hf;
    logic [31:0]   dat   = 32'h0;
    logic          stop  = 1'b0;
    logic          aw    = 1'b0;
    logic          prot  = 1'b0;
    logic          anyp  = 1'b0;
    logic [7:0]    lat   = 8'h14;
    logic          blank = 1'b0;
    logic [31:0]   dat_o;
    logic          ack_o;
    logic          irq_o;
    fcsl_eng_rsp_t eng_rsp;
    fcsl_eng_req_t eng_req;
    logic [7:0]    q;
    logic [7:0]    prev = 8'hc1;
    logic [7:0]    last_code;
    int            n_errors = 0;
    int            compares = 0;
    int            starts = 0;
    int            aborts = 0;
    int            s0;

    always #50 clk_i = ~clk_i;

    fcsl_top #(.ADR_W(8)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .stop_req_i(stop), .array_write_i(aw), .array_protected_i(prot), .any_protect_i(anyp),
        .eng_rsp_i(eng_rsp), .eng_req_o(eng_req), .irq_o(irq_o));

    fcsl_eng_model eng (.clk_i(clk_i), .rst_i(rst_i), .req_i(eng_req), .lat_i(lat),
        .blank_i(blank), .rsp_o(eng_rsp));

    always @(posedge clk_i) begin
        if (eng_req.start === 1'b1) begin
            starts++;
            last_code = eng_req.code;
        end
        if (eng_req.abort === 1'b1) begin
            aborts++;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t %s: got %h expected %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= {24'h0, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        chk({7'h0, ack_o}, 8'h01, "bus ack");
        @(posedge clk_i);
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
        wb(1'b0, a, 8'h00);
        chk(q, e, m);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic aw_pulse(input logic p);
        aw   <= 1'b1;
        prot <= p;
        @(posedge clk_i);
        aw   <= 1'b0;
        prot <= 1'b0;
    endtask : aw_pulse

    task automatic seq(input logic [7:0] c);
        aw_pulse(1'b0);
        wr(A_CMD, c);
    endtask : seq

    task automatic blocked_try(input string m);
        s0 = starts;
        seq(8'h20);
        wr(A_ST, 8'h80);
        repeat (5) @(posedge clk_i);
        chk(8'(starts - s0), 8'h00, m);
    endtask : blocked_try

    task automatic wait_done;
        int n;
        n = 0;
        while (eng_rsp.done !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        chk({7'h0, eng_rsp.done}, 8'h01, "engine done");
        repeat (2) @(posedge clk_i);
    endtask : wait_done

    task automatic end_of_test;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #1000000;
        n_errors++;
        $display("BAD t=%0t watchdog expired", $time);
        end_of_test();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({7'h0, irq_o}, 8'h00, "irq after reset");
        rd(A_ST, 8'hc1, "status after reset");
        rd(A_CMD, 8'h00, "command after reset");
        rd(A_IRQ, 8'h00, "irq status after reset");
        rd(8'h3c, 8'h00, "unmapped read");
        stop <= 1'b1;
        @(posedge clk_i);
        stop <= 1'b0;
        rd(A_ST, 8'hc1, "stop while idle");
        $display("reset test done");
        foreach (ROWS[i]) begin
            blank <= ROWS[i].blank;
            seq(ROWS[i].code);
            rd(A_ST, prev, "status mid sequence");
            rd(A_CMD, ROWS[i].code, "command readback");
            s0 = starts;
            wr(A_ST, 8'h80);
            wb(1'b0, A_ST, 8'h00);
            chk(q & 8'h44, 8'h00, "blank or complete while busy");
            wait_done();
            chk(8'(starts - s0), 8'h01, "one start");
            chk(last_code, ROWS[i].code, "engine code");
            rd(A_ST, ROWS[i].stat, "status after command");
            prev = ROWS[i].stat;
            $display("command row %0d done", i);
        end
        rd(A_IRQ, 8'h01, "complete irq status");
        rd(A_IRQ, 8'h00, "irq status read clears");
        aw_pulse(1'b1);
        rd(A_ST, 8'he1, "protect violation");
        wr(A_ST, 8'h00);
        rd(A_ST, 8'he1, "zero write keeps violation");
        chk({7'h0, irq_o}, 8'h00, "masked irq");
        wr(A_MSK, 8'h02);
        chk({7'h0, irq_o}, 8'h01, "unmasked irq");
        rd(A_IRQ, 8'h02, "violation irq status");
        chk({7'h0, irq_o}, 8'h00, "irq after read clear");
        blocked_try("violation blocks launch");
        wr(A_ST, 8'h30);
        rd(A_ST, 8'hc1, "violation cleared");
        $display("protection test done");
        aw_pulse(1'b0);
        wr(A_CMD, 8'hff);
        wb(1'b0, A_CMD, 8'h00);
        chk(q & 8'h9a, 8'h00, "fixed command bits");
        rd(A_ST, 8'hd1, "invalid code");
        wr(A_ST, 8'h00);
        rd(A_ST, 8'hd1, "zero write keeps access error");
        blocked_try("access error blocks launch");
        wr(A_ST, 8'h10);
        rd(A_ST, 8'hc1, "access error cleared");
        $display("access error test done");
        anyp <= 1'b1;
        aw_pulse(1'b0);
        wr(A_CMD, 8'h41);
        rd(A_ST, 8'he1, "mass erase while protected");
        anyp <= 1'b0;
        wr(A_ST, 8'h20);
        rd(A_ST, 8'hc1, "mass erase violation cleared");
        wr(A_CTL, 8'h01);
        blank <= 1'b0;
        seq(8'h05);
        wr(A_ST, 8'h80);
        wb(1'b0, A_ST, 8'h00);
        chk(q & 8'h41, 8'h00, "busy in special mode");
        wait_done();
        rd(A_ST, 8'hc3, "failed verify");
        blocked_try("failure blocks launch");
        wr(A_ST, 8'h12);
        rd(A_ST, 8'hc1, "failure cleared");
        wr(A_CTL, 8'h00);
        $display("special mode test done");
        lat <= 8'h3c;
        seq(8'h20);
        wr(A_ST, 8'h80);
        s0 = aborts;
        stop <= 1'b1;
        @(posedge clk_i);
        stop <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(8'(aborts - s0), 8'h01, "engine aborted");
        wb(1'b0, A_ST, 8'h00);
        chk(q & 8'h10, 8'h10, "stop while busy");
        wr(A_ST, 8'h10);
        wb(1'b0, A_ST, 8'h00);
        chk(q & 8'h10, 8'h00, "stop error cleared");
        $display("stop test done");
        end_of_test();
    end
endmodule : fcsl_top_tb
`default_nettype wire
